// *** ffvm_mapper.sv ***
// Notes on behaviour
// - Seed flag vector from parser's forty flags
// - Bit 37 set when checksum not ffff
// - Bit 38 short header; bit 39 parity
// - Bit 34 pause: second field is time
// - Bit 35 class pause only with 34
// - Bits 31:24 hold L3/L4 word offsets
// - Resolver mux copies offsets into payload
// - Bits 32/33 steer outer/inner VLAN remap
// - Bit 18 when destination MAC all ones
// - Bit 19 from IP version, address top
// - Bits 20/21 backbone state or label depth
// - Bits 23 and 36 pass parser value
// - Flags to vector, some to resolvers, keys
// - Each frame gets a scenario value
// - Port ranges compressed into short identifiers
// - Duplicate range maps configured independently
// - Outer and inner VLAN IDs remappable
//
// Implementation choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module ffvm_mapper
  import ffvm_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frame_valid_in,
  input wire logic [FFVM_PARSER_W-1:0] parser_flags_in,
  input wire logic [47:0] dest_mac_in,
  input wire logic [127:0] dest_ip_in,
  input wire logic [15:0] header_sum_in,
  input wire logic short_header_in,
  input wire logic parity_fault_in,
  input wire logic label_frame_in,
  input wire logic backbone_tagged_flag_in,
  input wire logic backbone_header_kind_in,
  input wire logic [1:0] label_stack_depth_in,
  input wire logic [FFVM_VID_W-1:0] outer_vid_in,
  input wire logic [FFVM_VID_W-1:0] inner_vid_in,
  input wire logic [15:0] l4_dst_port_in,
  input wire logic [7:0] ingress_port_number_in,
  input wire logic [15:0] first_short_field_in,
  input wire logic [15:0] second_short_field_in,
  input wire logic [15:0] third_short_field_in,
  input wire logic [15:0] fourth_short_field_in,
  output logic frame_valid_out,
  output logic [FFVM_FLAGS_W-1:0] flags_out,
  output logic [3:0] scenario_out,
  output logic [FFVM_VID_W-1:0] outer_vid_out,
  output logic [FFVM_VID_W-1:0] inner_vid_out,
  output logic [15:0] acl_port_id_out,
  output logic [15:0] route_port_id_out,
  output logic [7:0] action_payload_out,
  output logic [2:0] l3_offset_out,
  output logic [4:0] l4_offset_out,
  output logic pause_valid_out,
  output logic [7:0] pause_port_out,
  output logic [15:0] pause_time_out,
  output logic class_pause_valid_out,
  output logic [47:0] class_pause_info_out,
  output logic irq_out
);
  logic [5:0] ctrl_r;
  logic [FFVM_ST_W-1:0] status_r;
  logic [FFVM_ST_W-1:0] mask_r;
  logic [31:0] frames_r;
  logic [31:0] prdata_r;
  logic wr_en;
  logic rd_en;
  logic addr_ok;
  logic vid_we;
  logic range_we;
  logic [FFVM_ST_W-1:0] events;
  logic [FFVM_PARSER_W-1:0] s1_flags_r;
  logic [FFVM_VID_W-1:0] s1_outer_r;
  logic [FFVM_VID_W-1:0] s1_inner_r;
  logic [7:0] s1_port_r;
  logic [63:0] s1_fields_r;
  logic s1_valid_r;
  logic [FFVM_PARSER_W-1:0] flags_nxt;
  logic [FFVM_VMEM_DW-1:0] outer_map;
  logic [FFVM_VMEM_DW-1:0] inner_map;
  logic [15:0] acl_id;
  logic [15:0] route_id;
  logic [FFVM_VID_W-1:0] outer_nxt;
  logic [FFVM_VID_W-1:0] inner_nxt;
  logic fr_en;

  assign fr_en = frame_valid_in && ctrl_r[FFVM_CTRL_EN];

  // APB slave: zero wait states, unmapped offsets answer with pslverr
  always_comb begin
    unique case (paddr)
      FFVM_REG_CTRL, FFVM_REG_STATUS, FFVM_REG_MASK, FFVM_REG_FRAMES,
      FFVM_REG_VID_WR, FFVM_REG_RANGE_WR: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en = psel && penable && pwrite && addr_ok;
  assign rd_en = psel && !penable && !pwrite;
  assign vid_we = wr_en && paddr == FFVM_REG_VID_WR;
  assign range_we = wr_en && paddr == FFVM_REG_RANGE_WR;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      prdata_r <= '0;
    end else if (rd_en) begin
      unique case (paddr)
        FFVM_REG_CTRL: prdata_r <= {26'h0, ctrl_r};
        FFVM_REG_STATUS: prdata_r <= {28'h0, status_r};
        FFVM_REG_MASK: prdata_r <= {28'h0, mask_r};
        FFVM_REG_FRAMES: prdata_r <= frames_r;
        default: prdata_r <= 32'h0;
      endcase
    end
  end
  assign prdata = prdata_r;

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ctrl_r <= FFVM_CTRL_RESET;
    end else if (wr_en && paddr == FFVM_REG_CTRL) begin
      ctrl_r <= pwdata[5:0];
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mask_r <= FFVM_MASK_RESET;
    end else if (wr_en && paddr == FFVM_REG_MASK) begin
      mask_r <= pwdata[FFVM_ST_W-1:0];
    end
  end

  // Events are recorded at entry so status matches the frame that raised it
  assign events[FFVM_ST_SUM] = fr_en && header_sum_in != FFVM_SUM_GOOD;
  assign events[FFVM_ST_SHORT] = fr_en && short_header_in;
  assign events[FFVM_ST_PARITY] = fr_en && parity_fault_in;
  assign events[FFVM_ST_PAUSE] = fr_en && parser_flags_in[FFVM_BIT_PAUSE];

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_r <= '0;
    end else if (wr_en && paddr == FFVM_REG_STATUS) begin
      status_r <= (status_r & ~pwdata[FFVM_ST_W-1:0]) | events;
    end else begin
      status_r <= status_r | events;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_r & mask_r);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frames_r <= '0;
    end else if (fr_en) begin
      frames_r <= frames_r + 32'h1;
    end
  end

  // Stage 1: build the parser-side flags
  always_comb begin
    flags_nxt = parser_flags_in;
    flags_nxt[FFVM_BIT_L3_BCAST] = dest_mac_in == FFVM_MAC_ALL_ONES;
    flags_nxt[FFVM_BIT_IP_MCAST] =
      (parser_flags_in[FFVM_BIT_IS_IPV4] && dest_ip_in[31:28] == FFVM_V4_MCAST_TOP) ||
      (parser_flags_in[FFVM_BIT_IS_IPV6] && dest_ip_in[127:120] == FFVM_V6_MCAST_TOP);
    if (label_frame_in) begin
      flags_nxt[FFVM_BIT_BB_KIND:FFVM_BIT_BB_TAGGED] = label_stack_depth_in;
    end else begin
      flags_nxt[FFVM_BIT_BB_TAGGED] = backbone_tagged_flag_in;
      flags_nxt[FFVM_BIT_BB_KIND] = backbone_header_kind_in;
    end
    flags_nxt[FFVM_BIT_SUM_FAIL] = header_sum_in != FFVM_SUM_GOOD;
    flags_nxt[FFVM_BIT_SHORT_HDR] = short_header_in;
    flags_nxt[FFVM_BIT_PARITY] = parity_fault_in;
  end

  // Every per-frame field moves together under the same valid
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_valid_r <= 1'b0;
      s1_flags_r <= '0;
      s1_outer_r <= '0;
      s1_inner_r <= '0;
      s1_port_r <= '0;
      s1_fields_r <= '0;
    end else begin
      s1_valid_r <= fr_en;
      s1_flags_r <= flags_nxt;
      s1_outer_r <= outer_vid_in;
      s1_inner_r <= inner_vid_in;
      s1_port_r <= ingress_port_number_in;
      s1_fields_r <= {fourth_short_field_in, third_short_field_in, second_short_field_in, first_short_field_in};
    end
  end

  // Separate tables for each VLAN space, loaded through one write register
  ffvm_vid_mem u_outer_mem (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .we_in(vid_we && !pwdata[FFVM_VWR_SEL]),
    .waddr_in(pwdata[FFVM_VWR_IDX_LSB +: FFVM_VMEM_AW]),
    .wdata_in(pwdata[FFVM_VMEM_DW-1:0]),
    .raddr_in(outer_vid_in[FFVM_VMEM_AW-1:0]),
    .rdata_out(outer_map)
  );

  ffvm_vid_mem u_inner_mem (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .we_in(vid_we && pwdata[FFVM_VWR_SEL]),
    .waddr_in(pwdata[FFVM_VWR_IDX_LSB +: FFVM_VMEM_AW]),
    .wdata_in(pwdata[FFVM_VMEM_DW-1:0]),
    .raddr_in(inner_vid_in[FFVM_VMEM_AW-1:0]),
    .rdata_out(inner_map)
  );

  // Two independent range maps on the same port: one for ACLs, one for routing
  ffvm_range_map u_acl_range (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .cfg_we_in(range_we && !pwdata[FFVM_RWR_LAYER]),
    .cfg_entry_in(pwdata[FFVM_RWR_ENT_LSB +: 2]),
    .cfg_bound_in(pwdata[15:0]),
    .cfg_id_in(pwdata[FFVM_RWR_ID_LSB +: 8]),
    .cfg_valid_in(pwdata[FFVM_RWR_VALID]),
    .port_in(l4_dst_port_in),
    .id_out(acl_id)
  );

  ffvm_range_map u_route_range (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .cfg_we_in(range_we && pwdata[FFVM_RWR_LAYER]),
    .cfg_entry_in(pwdata[FFVM_RWR_ENT_LSB +: 2]),
    .cfg_bound_in(pwdata[15:0]),
    .cfg_id_in(pwdata[FFVM_RWR_ID_LSB +: 8]),
    .cfg_valid_in(pwdata[FFVM_RWR_VALID]),
    .port_in(l4_dst_port_in),
    .id_out(route_id)
  );

  // Final VID choice; the reserved code falls back to the raw ID
  always_comb begin
    unique case (ffvm_vmux_e'(ctrl_r[FFVM_CTRL_OMUX_LSB +: 2]))
      FFVM_VMUX_MAPPED: outer_nxt = outer_map[FFVM_VID_W-1:0];
      FFVM_VMUX_FLAG: outer_nxt = s1_flags_r[FFVM_BIT_OUTER_REMAP] ? outer_map[FFVM_VID_W-1:0] : s1_outer_r;
      default: outer_nxt = s1_outer_r;
    endcase
    unique case (ffvm_vmux_e'(ctrl_r[FFVM_CTRL_IMUX_LSB +: 2]))
      FFVM_VMUX_MAPPED: inner_nxt = inner_map[FFVM_VID_W-1:0];
      FFVM_VMUX_FLAG: inner_nxt = s1_flags_r[FFVM_BIT_INNER_REMAP] ? inner_map[FFVM_VID_W-1:0] : s1_inner_r;
      default: inner_nxt = s1_inner_r;
    endcase
  end

  // Stage 2: output registers
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frame_valid_out <= 1'b0;
      flags_out <= '0;
      scenario_out <= '0;
      outer_vid_out <= '0;
      inner_vid_out <= '0;
      acl_port_id_out <= '0;
      route_port_id_out <= '0;
    end else begin
      frame_valid_out <= s1_valid_r;
      // Table flag bits widen the vector beyond the parser's forty
      flags_out <= {inner_map[FFVM_VMEM_DW-1], outer_map[FFVM_VMEM_DW-1], s1_flags_r};
      scenario_out <= {s1_flags_r[FFVM_BIT_IS_IPV4] | s1_flags_r[FFVM_BIT_IS_IPV6],
                       s1_flags_r[FFVM_BIT_L3_BCAST], s1_flags_r[FFVM_BIT_IP_MCAST],
                       s1_flags_r[FFVM_BIT_PAUSE]};
      outer_vid_out <= outer_nxt;
      inner_vid_out <= inner_nxt;
      acl_port_id_out <= acl_id;
      route_port_id_out <= route_id;
    end
  end

  // Resolver-only outputs: offsets and the payload mux
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      action_payload_out <= '0;
      l3_offset_out <= '0;
      l4_offset_out <= '0;
    end else begin
      action_payload_out <= ctrl_r[FFVM_CTRL_PAYLOAD] ? s1_flags_r[FFVM_OFS_MSB:FFVM_OFS_LSB] : 8'h00;
      l3_offset_out <= s1_flags_r[FFVM_OFS_LSB +: FFVM_L3_OFS_MSB + 1];
      l4_offset_out <= s1_flags_r[FFVM_OFS_MSB:FFVM_OFS_LSB + FFVM_L4_OFS_LSB];
    end
  end

  // Pause indications for congestion management
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pause_valid_out <= 1'b0;
      pause_port_out <= '0;
      pause_time_out <= '0;
      class_pause_valid_out <= 1'b0;
      class_pause_info_out <= '0;
    end else begin
      pause_valid_out <= s1_valid_r && s1_flags_r[FFVM_BIT_PAUSE];
      pause_port_out <= s1_port_r;
      pause_time_out <= s1_fields_r[31:16];
      // Class bit alone is ignored
      class_pause_valid_out <= s1_valid_r && s1_flags_r[FFVM_BIT_PAUSE] && s1_flags_r[FFVM_BIT_CLASS_PAUSE];
      class_pause_info_out <= {s1_fields_r[63:32], s1_fields_r[15:0]};
    end
  end

  a_frame_latency: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    fr_en |-> ##2 frame_valid_out)
    else $error("frame valid not delivered two cycles later");
  a_seed_flags: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    fr_en |-> ##2 flags_out[FFVM_SEED_HI:0] == $past(parser_flags_in[FFVM_SEED_HI:0], 2))
    else $error("seeded flags differ from parser flags");
  a_sum_fail_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    fr_en && header_sum_in != FFVM_SUM_GOOD |-> ##2 flags_out[FFVM_BIT_SUM_FAIL])
    else $error("checksum failure flag missing");
  a_fault_flags: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    fr_en |-> ##2 flags_out[FFVM_BIT_PARITY:FFVM_BIT_SHORT_HDR] == $past({parity_fault_in, short_header_in}, 2))
    else $error("short header or parity flag wrong");
  a_pause_time: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    fr_en && parser_flags_in[FFVM_BIT_PAUSE] |-> ##2 pause_valid_out && pause_time_out == $past(second_short_field_in, 2))
    else $error("pause time not taken from second field");
  a_class_gate: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    class_pause_valid_out |-> pause_valid_out && flags_out[FFVM_BIT_PAUSE])
    else $error("class pause without pause flag");
  a_payload_mux: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    frame_valid_out && $past(ctrl_r[FFVM_CTRL_PAYLOAD]) |-> action_payload_out == flags_out[FFVM_OFS_MSB:FFVM_OFS_LSB])
    else $error("payload does not carry header offsets");
  a_bcast_flag: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    fr_en |-> ##2 flags_out[FFVM_BIT_L3_BCAST] == ($past(dest_mac_in, 2) == FFVM_MAC_ALL_ONES))
    else $error("broadcast flag mismatch");
  a_mcast_v4: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    fr_en && parser_flags_in[FFVM_BIT_IS_IPV4] && dest_ip_in[31:28] == FFVM_V4_MCAST_TOP
    |-> ##2 flags_out[FFVM_BIT_IP_MCAST])
    else $error("IPv4 multicast flag missing");
  a_vid_raw: assert property (@(posedge clk_sys_in) disable iff (!rst_n_in)
    fr_en && ctrl_r[FFVM_CTRL_OMUX_LSB +: 2] == 2'h0 ##1 ctrl_r[FFVM_CTRL_OMUX_LSB +: 2] == 2'h0
    |=> outer_vid_out == $past(outer_vid_in, 2))
    else $error("outer VID altered in raw mode");
endmodule // ffvm_mapper
`default_nettype wire

// *** ffvm_mapper_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module ffvm_mapper_bench;
  logic clk_sys_in = 0;
  logic rst_n_in = 0;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, q;
  logic pready, pslverr, e, go = 0, fv, fvo, pv, cpv, irq;
  logic [39:0] m_flags = 0, p_flags;
  logic [47:0] m_mac = 0, p_mac, cinfo;
  logic [15:0] m_sum = 16'hffff, p_sum, ptime;
  logic [127:0] dip = 0;
  logic shrt = 0, par = 0, lbl = 0, bbt = 0, bbk = 0;
  logic [1:0] dep = 0;
  logic [11:0] ovid = 12'h005, ivid = 12'h006, ovo, ivo;
  logic [15:0] l4p = 16'h0050, acl, rte;
  logic [3:0] scn;
  logic [7:0] pport, payload;
  logic [41:0] flags;
  logic [2:0] l3o;
  logic [4:0] l4o;
  int error_cnt = 0, samples_checked = 0, nfr = 0;

  always #12.5 clk_sys_in = ~clk_sys_in;

  ffvm_parser_model u_parser (.clk_sys_in, .go_in(go), .flags_in(m_flags), .mac_in(m_mac), .sum_in(m_sum),
    .frame_valid_out(fv), .flags_out(p_flags), .mac_out(p_mac), .sum_out(p_sum));

  ffvm_mapper u_dut (.clk_sys_in, .rst_n_in, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .frame_valid_in(fv), .parser_flags_in(p_flags), .dest_mac_in(p_mac), .dest_ip_in(dip),
    .header_sum_in(p_sum), .short_header_in(shrt), .parity_fault_in(par), .label_frame_in(lbl),
    .backbone_tagged_flag_in(bbt), .backbone_header_kind_in(bbk), .label_stack_depth_in(dep),
    .outer_vid_in(ovid), .inner_vid_in(ivid), .l4_dst_port_in(l4p),
    .ingress_port_number_in(8'h5a), .first_short_field_in(16'h1111), .second_short_field_in(16'h2222),
    .third_short_field_in(16'h3333), .fourth_short_field_in(16'h4444), .frame_valid_out(fvo),
    .flags_out(flags), .scenario_out(scn), .outer_vid_out(ovo), .inner_vid_out(ivo), .acl_port_id_out(acl),
    .route_port_id_out(rte), .action_payload_out(payload), .l3_offset_out(l3o), .l4_offset_out(l4o),
    .pause_valid_out(pv), .pause_port_out(pport), .pause_time_out(ptime), .class_pause_valid_out(cpv),
    .class_pause_info_out(cinfo), .irq_out(irq));

  task chk(input string n, input logic [47:0] s, input logic [47:0] x);
    samples_checked++;
    if (s !== x) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, x, s);
    end
  endtask

  // Request held until pready is sampled high, then released
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_in);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk_sys_in);
    penable <= 1;
    do @(posedge clk_sys_in); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask

  // Model launches one cycle after go; outputs land two cycles after acceptance
  task frame(input logic [39:0] f, input logic [47:0] m, input logic [15:0] s);
    @(posedge clk_sys_in);
    {go, m_flags, m_mac, m_sum} <= {1'b1, f, m, s};
    @(posedge clk_sys_in);
    go <= 0;
    repeat (2) @(posedge clk_sys_in);
    #1;
    nfr++;
  endtask

  task t_err;
    {shrt, par} <= 2'b11;
    frame(0, 0, 16'h1234);
    chk("fault bits", {fvo, flags[39:37]}, 4'hf);
    {shrt, par} <= 2'b00;
    frame(0, 0, 16'hffff);
    chk("clean bits", {fvo, flags[39:37]}, 4'h8);
    chk("irq masked", irq, 0);
    apb(1, 8'h08, 32'h1);
    repeat (2) @(posedge clk_sys_in);
    chk("irq set", irq, 1);
    apb(1, 8'h04, 32'hf);
    repeat (2) @(posedge clk_sys_in);
    chk("irq clear", irq, 0);
    apb(0, 8'h04, 0);
    chk("status", q, 0);
  endtask

  task t_cast;
    dip <= 128'he000_0001;
    frame(40'h100, 48'hffff_ffff_ffff, 16'hffff);
    chk("v4 cast", flags[19:18], 2'b11);
    dip <= {8'hff, 120'h1};
    frame(40'h200, 48'h1, 16'hffff);
    chk("v6 cast", flags[19:18], 2'b10);
    dip <= 128'h0a00_0001;
    frame(40'h100, 48'h1, 16'hffff);
    chk("no cast", flags[19:18], 2'b00);
  endtask

  task t_pause;
    frame(40'h1 << 34, 0, 16'hffff);
    chk("pause", {pv, cpv, pport, ptime}, {2'b10, 8'h5a, 16'h2222});
    frame(40'h3 << 34, 0, 16'hffff);
    chk("class pause", {cpv, cinfo}, {1'b1, 48'h4444_3333_1111});
    frame(40'h1 << 35, 0, 16'hffff);
    chk("class alone", {pv, cpv}, 2'b00);
  endtask

  task t_ofs;
    apb(1, 8'h00, 32'h21);
    frame(40'hab << 24, 0, 16'hffff);
    chk("offsets", {flags[31:24], l3o, l4o, payload}, {8'hab, 3'h3, 5'h15, 8'hab});
    apb(1, 8'h00, 32'h1);
    frame(40'hab << 24, 0, 16'hffff);
    chk("payload off", payload, 0);
  endtask

  task t_bits;
    {lbl, dep} <= 3'b110;
    frame(40'h3 << 32, 0, 16'hffff);
    chk("depth", flags[33:20] & 14'h3003, 14'h3002);
    {lbl, bbt, bbk} <= 3'b010;
    frame(0, 0, 16'hffff);
    chk("backbone", flags[21:20], 2'b01);
  endtask

  task t_b2b;
    @(posedge clk_sys_in);
    {go, m_flags} <= {1'b1, 40'h1 << 23};
    @(posedge clk_sys_in);
    m_flags <= 40'h1 << 36;
    @(posedge clk_sys_in);
    go <= 0;
    @(posedge clk_sys_in);
    #1;
    chk("first", {fvo, flags[36], flags[23]}, 3'b101);
    @(posedge clk_sys_in);
    #1;
    chk("second", {fvo, flags[36], flags[23]}, 3'b110);
    nfr += 2;
  endtask

  // Outer table mapped, inner table steered by flag bit 33; ACL and route maps loaded differently
  task t_map;
    apb(1, 8'h10, 32'h0000_b123);
    apb(1, 8'h10, 32'h0008_c456);
    apb(1, 8'h14, 32'h0107_0040);
    apb(1, 8'h14, 32'h0b09_0100);
    apb(1, 8'h00, 32'h13);
    frame(40'h06_0000_0100, 48'hffff_ffff_ffff, 16'hffff);
    chk("vids", {ovo, ivo, flags[41:40]}, {12'h123, 12'h456, 2'b01});
    chk("port ids", {acl, rte}, {16'h0007, 16'h0050});
    chk("scenario", scn, 4'hd);
    l4p <= 16'h0200;
    frame(0, 0, 16'hffff);
    chk("raw inner", {ovo, ivo}, {12'h123, 12'h006});
    chk("route id", {acl, rte}, {16'h0007, 16'h0009});
    chk("scenario idle", scn, 4'h0);
  endtask

  task t_off;
    apb(1, 8'h00, 0);
    frame(0, 0, 16'hffff);
    nfr--;
    chk("dropped", fvo, 0);
    apb(1, 8'h00, 32'h1);
    apb(0, 8'h0c, 0);
    chk("frames", q, nfr);
    apb(0, 8'h20, 0);
    chk("unmapped", {e, q}, 33'h1_0000_0000);
  endtask

  task finish_test;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk_sys_in);
    rst_n_in <= 1;
    t_err;
    t_cast;
    t_pause;
    t_ofs;
    t_bits;
    t_b2b;
    t_map;
    t_off;
    finish_test;
  end

  // The sequence needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk_sys_in);
    error_cnt++;
    finish_test;
  end
endmodule // ffvm_mapper_bench
`default_nettype wire

// *** ffvm_parser_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ffvm_parser_model (
  input wire logic clk_sys_in,
  input wire logic go_in,
  input wire logic [39:0] flags_in,
  input wire logic [47:0] mac_in,
  input wire logic [15:0] sum_in,
  output logic frame_valid_out,
  output logic [39:0] flags_out,
  output logic [47:0] mac_out,
  output logic [15:0] sum_out
);
  // Between frames the data shows the inverse, so stale values never look valid
  always_ff @(posedge clk_sys_in) begin
    frame_valid_out <= go_in;
    flags_out <= go_in ? flags_in : ~flags_in;
    mac_out <= go_in ? mac_in : ~mac_in;
    sum_out <= go_in ? sum_in : ~sum_in;
  end
endmodule // ffvm_parser_model
`default_nettype wire

// *** ffvm_pkg.sv ***
`default_nettype none
package ffvm_pkg;
  // Flag vector geometry
  localparam int FFVM_PARSER_W = 40;
  localparam int FFVM_FLAGS_W = 42;
  localparam int FFVM_SEED_HI = 17;
  localparam int FFVM_BIT_L3_BCAST = 18;
  localparam int FFVM_BIT_IP_MCAST = 19;
  localparam int FFVM_BIT_BB_TAGGED = 20;
  localparam int FFVM_BIT_BB_KIND = 21;
  localparam int FFVM_BIT_HOPBYHOP = 22;
  localparam int FFVM_BIT_FREE_LO = 23;
  localparam int FFVM_OFS_LSB = 24;
  localparam int FFVM_OFS_MSB = 31;
  localparam int FFVM_BIT_OUTER_REMAP = 32;
  localparam int FFVM_BIT_INNER_REMAP = 33;
  localparam int FFVM_BIT_PAUSE = 34;
  localparam int FFVM_BIT_CLASS_PAUSE = 35;
  localparam int FFVM_BIT_FREE_HI = 36;
  localparam int FFVM_BIT_SUM_FAIL = 37;
  localparam int FFVM_BIT_SHORT_HDR = 38;
  localparam int FFVM_BIT_PARITY = 39;
  localparam int FFVM_BIT_OUTER_TBL = 40;
  localparam int FFVM_BIT_INNER_TBL = 41;
  localparam int FFVM_BIT_IS_IPV4 = 8;
  localparam int FFVM_BIT_IS_IPV6 = 9;
  // Header offset sub-fields
  localparam int FFVM_L3_OFS_MSB = 2;
  localparam int FFVM_L4_OFS_LSB = 3;
  localparam logic [15:0] FFVM_SUM_GOOD = 16'hffff;
  localparam logic [47:0] FFVM_MAC_ALL_ONES = 48'hffff_ffff_ffff;
  localparam logic [3:0] FFVM_V4_MCAST_TOP = 4'he;
  localparam logic [7:0] FFVM_V6_MCAST_TOP = 8'hff;
  // Table geometry
  localparam int FFVM_VID_W = 12;
  localparam int FFVM_VMEM_AW = 6;
  localparam int FFVM_VMEM_DW = 13;
  localparam int FFVM_RANGE_N = 4;
  // APB register byte offsets
  localparam logic [7:0] FFVM_REG_CTRL = 8'h00;
  localparam logic [7:0] FFVM_REG_STATUS = 8'h04;
  localparam logic [7:0] FFVM_REG_MASK = 8'h08;
  localparam logic [7:0] FFVM_REG_FRAMES = 8'h0c;
  localparam logic [7:0] FFVM_REG_VID_WR = 8'h10;
  localparam logic [7:0] FFVM_REG_RANGE_WR = 8'h14;
  // CTRL fields
  localparam int FFVM_CTRL_EN = 0;
  localparam int FFVM_CTRL_OMUX_LSB = 1;
  localparam int FFVM_CTRL_IMUX_LSB = 3;
  localparam int FFVM_CTRL_PAYLOAD = 5;
  localparam logic [5:0] FFVM_CTRL_RESET = 6'h01;
  // VID_WR fields
  localparam int FFVM_VWR_IDX_LSB = 13;
  localparam int FFVM_VWR_SEL = 19;
  // RANGE_WR fields
  localparam int FFVM_RWR_ID_LSB = 16;
  localparam int FFVM_RWR_VALID = 24;
  localparam int FFVM_RWR_ENT_LSB = 25;
  localparam int FFVM_RWR_LAYER = 27;
  // Status bits
  localparam int FFVM_ST_W = 4;
  localparam int FFVM_ST_SUM = 0;
  localparam int FFVM_ST_SHORT = 1;
  localparam int FFVM_ST_PARITY = 2;
  localparam int FFVM_ST_PAUSE = 3;
  localparam logic [3:0] FFVM_MASK_RESET = 4'h0;
  // VID output mux selections
  typedef enum logic [1:0] {
    FFVM_VMUX_RAW,
    FFVM_VMUX_MAPPED,
    FFVM_VMUX_FLAG,
    FFVM_VMUX_RSVD
  } ffvm_vmux_e;
endpackage
`default_nettype wire

// *** ffvm_range_map.sv ***
`timescale 1ns/1ps
`default_nettype none
module ffvm_range_map
  import ffvm_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic cfg_we_in,
  input wire logic [1:0] cfg_entry_in,
  input wire logic [15:0] cfg_bound_in,
  input wire logic [7:0] cfg_id_in,
  input wire logic cfg_valid_in,
  input wire logic [15:0] port_in,
  output logic [15:0] id_out
);
  logic [15:0] bound_r [FFVM_RANGE_N];
  logic [7:0] ident_r [FFVM_RANGE_N];
  logic [FFVM_RANGE_N-1:0] valid_r;
  logic [FFVM_RANGE_N-1:0] hit;
  logic [15:0] id_nxt;
  logic [15:0] id_r;

  genvar g;
  generate
    for (g = 0; g < FFVM_RANGE_N; g++) begin : g_entry
      always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          bound_r[g] <= '0;
          ident_r[g] <= '0;
          valid_r[g] <= 1'b0;
        end else if (cfg_we_in && cfg_entry_in == 2'(g)) begin
          bound_r[g] <= cfg_bound_in;
          ident_r[g] <= cfg_id_in;
          valid_r[g] <= cfg_valid_in;
        end
      end
      assign hit[g] = valid_r[g] && (bound_r[g] < port_in);
    end
  endgenerate

  // Highest matching entry wins; no match keeps the raw port so exact keys still work
  always_comb begin
    id_nxt = port_in;
    for (int i = 0; i < FFVM_RANGE_N; i++) begin
      if (hit[i]) begin
        id_nxt = {8'h00, ident_r[i]};
      end
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      id_r <= '0;
    end else begin
      id_r <= id_nxt;
    end
  end

  assign id_out = id_r;
endmodule // ffvm_range_map
`default_nettype wire

// *** ffvm_vid_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module ffvm_vid_mem
  import ffvm_pkg::*;
(
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  input wire logic we_in,
  input wire logic [FFVM_VMEM_AW-1:0] waddr_in,
  input wire logic [FFVM_VMEM_DW-1:0] wdata_in,
  input wire logic [FFVM_VMEM_AW-1:0] raddr_in,
  output logic [FFVM_VMEM_DW-1:0] rdata_out
);
  logic [FFVM_VMEM_DW-1:0] mem_r [2**FFVM_VMEM_AW];
  logic [FFVM_VMEM_DW-1:0] rdata_r;

  // Array left unreset so it maps onto plain RAM; software loads it before enabling
  always_ff @(posedge clk_sys_in) begin
    if (we_in) begin
      mem_r[waddr_in] <= wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= mem_r[raddr_in];
    end
  end

  assign rdata_out = rdata_r;
endmodule // ffvm_vid_mem
`default_nettype wire
